// [hw/occb_bridge_ctl.sv]
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module occb_bridge_ctl (
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        bridge_disable_n,
   input  wire logic [1:0]  chopCmp,
   input  wire logic [3:0]  hiGateOffPin,
   input  wire logic [3:0]  loGateOffPin,
   output logic [3:0]       hiGate,
   output logic [3:0]       loGate,
   output logic [7:0]       coilTargetA,
   output logic [7:0]       coilTargetB,
   output logic [1:0]       lsDrive,
   output logic [1:0]       hsDrive,
   output logic             hsTempComp
);

   typedef struct packed {
      logic [10:0] s1;
      logic [10:0] s2;
      logic [10:0] s3;
      logic [10:0] filt;
      logic [15:0] lfsr;
      logic [18:0] ctrl;
      logic [31:0] target;
      logic        awHeld;
      logic [7:0]  awAddr;
      logic        wHeld;
      logic [31:0] wData;
      logic [3:0]  wStrb;
      logic        bValid;
      logic [1:0]  bResp;
      logic        rValid;
      logic [31:0] rData;
      logic [1:0]  rResp;
      logic [7:0]  tgtA;
      logic [7:0]  tgtB;
      logic [1:0]  lsDrv;
      logic [1:0]  hsDrv;
      logic        hsTc;
   } occb_top_s;

   occb_top_s                  q;
   occb_top_s                  d;
   occb_pkg::occb_cfg_s        cfg;
   occb_pkg::occb_phase_e      phase [2];
   occb_pkg::occb_hb_s         req   [4];
   occb_pkg::occb_hb_s         gate  [4];
   logic                       bridgeOn;
   logic [31:0]                hystView;
   logic [31:0]                statusView;
   logic [1:0]                 decSel;
   logic [31:0]                ctrlMerged;

   function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // offset code minus three, clamped into the 8-bit target range
   function automatic logic [7:0] adjTarget(input logic [7:0] mag,
                                            input logic [3:0] code,
                                            input logic       useOffs);
      logic signed [9:0] sum;
      sum = $signed({2'b00, mag});
      if (useOffs) begin
         sum = sum + $signed({6'h00, code}) - occb_pkg::OFFS_ZERO;
      end
      if (sum < 0) begin
         return 8'h00;
      end else if (sum > 10'sh0ff) begin
         return 8'hff;
      end else begin
         return sum[7:0];
      end
   endfunction

   function automatic logic [1:0] driveLevel(input logic [1:0] slope);
      unique case (slope)
         2'b00:   return occb_pkg::DRV_MIN;
         2'b01:   return occb_pkg::DRV_MIN;
         2'b10:   return occb_pkg::DRV_MED;
         2'b11:   return occb_pkg::DRV_MAX;
      endcase
   endfunction

   assign cfg      = occb_pkg::occb_cfg_s'(q.ctrl);
   assign bridgeOn = !q.filt[0] && (cfg.offTimeSetting != 4'h0);
   assign decSel   = {cfg.timeOnly, cfg.fastDecayDuration[3]};
   // merged as a full bus word, only the low control bits are kept
   assign ctrlMerged = mergeBytes({13'h0000, q.ctrl}, q.wData, q.wStrb);

   // style 0 view: start 1..8, signed end, decrement interval in clocks
   assign hystView = {15'h0000, cfg.chopperStyleSelect,
                      7'({1'b0, decSel, 4'h0}) + occb_pkg::DEC_STEP,
                      5'({1'b0, cfg.offs}) - 5'h03,
                      {1'b0, cfg.fastDecayDuration[2:0]} + 4'h1};

   assign statusView = {16'h0000,
                        loGate, hiGate,
                        3'h0, bridgeOn,
                        phase[1], phase[0]};

   assign s_axi_awready = !q.awHeld && !q.bValid;
   assign s_axi_wready  = !q.wHeld && !q.bValid;
   assign s_axi_arready = !q.rValid;

   always_comb begin
      d    = q;
      d.s1 = {loGateOffPin, hiGateOffPin, chopCmp, bridge_disable_n};
      d.s2 = q.s1;
      d.s3 = q.s2;
      // a change counts once the second and third stages agree
      d.filt = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.filt);
      d.lfsr = {q.lfsr[14:0], q.lfsr[15] ^ q.lfsr[13] ^ q.lfsr[12] ^ q.lfsr[10]};
      if (s_axi_awvalid && s_axi_awready) begin
         d.awHeld = 1'b1;
         d.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         d.wHeld = 1'b1;
         d.wData = s_axi_wdata;
         d.wStrb = s_axi_wstrb;
      end
      if (q.awHeld && q.wHeld) begin
         d.awHeld = 1'b0;
         d.wHeld  = 1'b0;
         d.bValid = 1'b1;
         d.bResp  = occb_pkg::RESP_OKAY;
         if (q.awAddr == occb_pkg::ADDR_CTRL) begin
            d.ctrl = ctrlMerged[occb_pkg::CTRL_W-1:0];
         end else if (q.awAddr == occb_pkg::ADDR_TARGET) begin
            d.target = mergeBytes(q.target, q.wData, q.wStrb);
         end else if (q.awAddr != occb_pkg::ADDR_STATUS && q.awAddr != occb_pkg::ADDR_HYST) begin
            d.bResp = occb_pkg::RESP_SLVERR;
         end
      end
      if (q.bValid && s_axi_bready) begin
         d.bValid = 1'b0;
      end
      if (q.rValid && s_axi_rready) begin
         d.rValid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         d.rValid = 1'b1;
         d.rResp  = occb_pkg::RESP_OKAY;
         unique case (s_axi_araddr)
            occb_pkg::ADDR_CTRL:   d.rData = {13'h0000, q.ctrl};
            occb_pkg::ADDR_TARGET: d.rData = q.target;
            occb_pkg::ADDR_STATUS: d.rData = statusView;
            occb_pkg::ADDR_HYST:   d.rData = hystView;
            default: begin
               d.rData = 32'h0000_0000;
               d.rResp = occb_pkg::RESP_SLVERR;
            end
         endcase
      end
      // offset only applies in style 1
      d.tgtA = adjTarget(q.target[occb_pkg::TGT_A_LSB +: 8], cfg.offs,
                         cfg.chopperStyleSelect);
      d.tgtB = adjTarget(q.target[occb_pkg::TGT_B_LSB +: 8], cfg.offs,
                         cfg.chopperStyleSelect);
      d.lsDrv = driveLevel(cfg.lowSideSlope);
      d.hsDrv = driveLevel(cfg.highSideSlope);
      d.hsTc  = (cfg.highSideSlope == 2'b01) || (cfg.highSideSlope == 2'b10);
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         q        <= '0;
         q.s1     <= occb_pkg::SYNC_RST;
         q.s2     <= occb_pkg::SYNC_RST;
         q.s3     <= occb_pkg::SYNC_RST;
         q.filt   <= occb_pkg::SYNC_RST;
         q.lfsr   <= occb_pkg::LFSR_SEED;
         q.ctrl   <= occb_pkg::CTRL_RST;
         q.target <= occb_pkg::TARGET_RST;
      end else begin
         q <= d;
      end
   end

   // each coil owns its own chopper state, no shared timing
   for (genvar c = 0; c < 2; c++) begin : g_coil
      occb_coil_chopper u_coil (
         .sys_clk  (sys_clk),
         .reset    (reset),
         .cfg      (cfg),
         .enable   (bridgeOn),
         .cmpTrip  (q.filt[1 + c]),
         .polarity (q.target[c == 0 ? occb_pkg::POL_A_BIT : occb_pkg::POL_B_BIT]),
         .rnd      (q.lfsr[c*8 +: 4]),
         .phase    (phase[c]),
         .hbOne    (req[2*c]),
         .hbTwo    (req[2*c + 1])
      );
   end

   for (genvar h = 0; h < 4; h++) begin : g_half
      occb_gate_guard u_guard (
         .sys_clk   (sys_clk),
         .reset     (reset),
         .req       (req[h]),
         .hiGateOff (q.filt[3 + h]),
         .loGateOff (q.filt[7 + h]),
         .gate      (gate[h])
      );
      assign hiGate[h] = gate[h].hi;
      assign loGate[h] = gate[h].lo;
   end

   assign s_axi_bvalid = q.bValid;
   assign s_axi_bresp  = q.bResp;
   assign s_axi_rvalid = q.rValid;
   assign s_axi_rdata  = q.rData;
   assign s_axi_rresp  = q.rResp;
   assign coilTargetA  = q.tgtA;
   assign coilTargetB  = q.tgtB;
   assign lsDrive      = q.lsDrv;
   assign hsDrive      = q.hsDrv;
   assign hsTempComp   = q.hsTc;

   a_disable_gates_off: assert property (
      @(posedge sys_clk) disable iff (reset)
      q.filt[0] |-> ##2 (hiGate == 4'h0 && loGate == 4'h0))
      else $error("bridge still driven while disable pin high");

   a_offtime_zero_off: assert property (
      @(posedge sys_clk) disable iff (reset)
      (cfg.offTimeSetting == 4'h0) [*3] |-> (hiGate == 4'h0 && loGate == 4'h0))
      else $error("bridge driven with zero off-time setting");

   a_ls_slope_map: assert property (
      @(posedge sys_clk) disable iff (reset)
      (cfg.lowSideSlope == 2'b01) [*2]
      |-> lsDrive == occb_pkg::DRV_MIN)
      else $error("low-side slope 01 not mapped to minimum");

   a_ls_slope_max: assert property (
      @(posedge sys_clk) disable iff (reset)
      (cfg.lowSideSlope == 2'b11) [*2] |-> lsDrive == occb_pkg::DRV_MAX)
      else $error("low-side slope 11 not mapped to maximum");

   a_hs_slope_map: assert property (
      @(posedge sys_clk) disable iff (reset)
      (cfg.highSideSlope == 2'b10) [*2] |-> (hsDrive == occb_pkg::DRV_MED && hsTempComp))
      else $error("high-side slope 10 not medium with compensation");

   a_offset_applied: assert property (
      @(posedge sys_clk) disable iff (reset)
      (cfg.chopperStyleSelect && cfg.offs == 4'h0 && q.target[7:0] == 8'h64) [*2]
      |-> coilTargetA == 8'h61)
      else $error("offset code 0 did not subtract three");

   a_offset_max: assert property (
      @(posedge sys_clk) disable iff (reset)
      (cfg.chopperStyleSelect && cfg.offs == 4'hf && q.target[23:16] == 8'h50) [*2]
      |-> coilTargetB == 8'h5c)
      else $error("offset code 15 did not add twelve");

endmodule
`default_nettype wire

// [hw/occb_pkg.sv]
package occb_pkg;

   // register byte addresses on the AXI4-Lite slave
   localparam logic [7:0]  ADDR_CTRL    = 8'h00;
   localparam logic [7:0]  ADDR_TARGET  = 8'h04;
   localparam logic [7:0]  ADDR_STATUS  = 8'h08;
   localparam logic [7:0]  ADDR_HYST    = 8'h0c;

   // control word field positions
   localparam int          CTRL_W       = 19;
   localparam int          OFFT_LSB     = 0;
   localparam int          FDUR_LSB     = 4;
   localparam int          OFFS_LSB     = 8;
   localparam int          TONLY_BIT    = 12;
   localparam int          RND_BIT      = 13;
   localparam int          STYLE_BIT    = 14;
   localparam int          LSLOPE_LSB   = 15;
   localparam int          HSLOPE_LSB   = 17;
   // chopper style 1, zero offset, off-time 0 so the bridge starts disabled
   localparam logic [18:0] CTRL_RST     = 19'h04300;

   // target word field positions
   localparam int          TGT_A_LSB    = 0;
   localparam int          POL_A_BIT    = 8;
   localparam int          TGT_B_LSB    = 16;
   localparam int          POL_B_BIT    = 24;
   localparam logic [31:0] TARGET_RST   = 32'h0000_0000;

   // chopper timing in system clock cycles, and the offset code that means zero offset
   localparam logic [9:0]  OFF_BASE_CYC = 10'h018;
   localparam int          OFF_STEP_SH  = 5;
   localparam int          FD_STEP_SH   = 5;
   localparam logic signed [9:0] OFFS_ZERO = 10'sh003;
   localparam logic [6:0]  DEC_STEP     = 7'h10;

   // synchroniser vector: [0] disable pin, [2:1] comparators, [6:3] hi off, [10:7] lo off
   localparam int          SYNC_W       = 11;
   localparam logic [10:0] SYNC_RST     = 11'h001;
   localparam logic [15:0] LFSR_SEED    = 16'hace1;

   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   localparam logic [1:0]  DRV_MIN      = 2'h0;
   localparam logic [1:0]  DRV_MED      = 2'h1;
   localparam logic [1:0]  DRV_MAX      = 2'h2;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_ON   = 2'b01,
      PH_FAST = 2'b10,
      PH_SLOW = 2'b11
   } occb_phase_e;

   typedef struct packed {
      logic [1:0] highSideSlope;
      logic [1:0] lowSideSlope;
      logic       chopperStyleSelect;
      logic       rndEn;
      logic       timeOnly;
      logic [3:0] offs;
      logic [3:0] fastDecayDuration;
      logic [3:0] offTimeSetting;
   } occb_cfg_s;

   typedef struct packed {
      logic hi;
      logic lo;
   } occb_hb_s;

endpackage

// [hw/occb_bbm.sv]
`timescale 1ns/100ps
`default_nettype none
module occb_gate_guard (
   input  wire logic              sys_clk,
   input  wire logic              reset,
   input  wire occb_pkg::occb_hb_s req,
   input  wire logic              hiGateOff,
   input  wire logic              loGateOff,
   output occb_pkg::occb_hb_s     gate
);

   occb_pkg::occb_hb_s q;
   occb_pkg::occb_hb_s d;

   // a side turns on only once the other side is off and its gate reads discharged
   always_comb begin
      d    = q;
      d.hi = req.hi && !req.lo && (q.hi || (!q.lo && loGateOff));
      d.lo = req.lo && !req.hi && (q.lo || (!q.hi && hiGateOff));
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign gate = q;

   a_guard_no_overlap: assert property (
      @(posedge sys_clk) disable iff (reset) !(q.hi && q.lo))
      else $error("both transistors of a half-bridge are on");

   a_guard_hi_waits: assert property (
      @(posedge sys_clk) disable iff (reset)
      $rose(q.hi) |-> ($past(loGateOff) && !$past(q.lo)))
      else $error("high side turned on before low gate discharged");

   a_guard_lo_waits: assert property (
      @(posedge sys_clk) disable iff (reset)
      $rose(q.lo) |-> ($past(hiGateOff) && !$past(q.hi)))
      else $error("low side turned on before high gate discharged");

endmodule
`default_nettype wire

// [hw/occb_coil_chopper.sv]
`timescale 1ns/100ps
`default_nettype none
module occb_coil_chopper (
   input  wire logic                sys_clk,
   input  wire logic                reset,
   input  wire occb_pkg::occb_cfg_s cfg,
   input  wire logic                enable,
   input  wire logic                cmpTrip,
   input  wire logic                polarity,
   input  wire logic [3:0]          rnd,
   output occb_pkg::occb_phase_e    phase,
   output occb_pkg::occb_hb_s       hbOne,
   output occb_pkg::occb_hb_s       hbTwo
);

   typedef struct packed {
      occb_pkg::occb_phase_e phase;
      logic [9:0]            cnt;
      logic [9:0]            slowLen;
      logic [9:0]            offLen;
   } occb_coil_s;

   occb_coil_s q;
   occb_coil_s d;
   logic [9:0] offCyc;
   logic [3:0] fdEff;

   always_comb begin
      offCyc = occb_pkg::OFF_BASE_CYC
               + 10'({cfg.offTimeSetting, 5'h00})
               + (cfg.rndEn ? {6'h00, rnd} : 10'h000);
      // style 0 runs slow decay only; fast decay fields are hysteresis bits then
      fdEff = cfg.chopperStyleSelect ? cfg.fastDecayDuration : 4'h0;
      d = q;
      d.slowLen = (q.phase == occb_pkg::PH_SLOW) ? q.slowLen + 10'h001 : 10'h000;
      unique case (q.phase)
         occb_pkg::PH_IDLE: begin
            d.phase = occb_pkg::PH_ON;
         end
         occb_pkg::PH_ON: begin
            if (cmpTrip) begin
               if (fdEff != 4'h0) begin
                  d.phase = occb_pkg::PH_FAST;
                  d.cnt   = 10'({fdEff, 5'h00}) - 10'h001;
               end else begin
                  d.phase  = occb_pkg::PH_SLOW;
                  d.cnt    = offCyc - 10'h001;
                  d.offLen = offCyc;
               end
            end
         end
         occb_pkg::PH_FAST: begin
            if (q.cnt == 10'h000 || (!cfg.timeOnly && cmpTrip)) begin
               d.phase  = occb_pkg::PH_SLOW;
               d.cnt    = offCyc - 10'h001;
               d.offLen = offCyc;
            end else begin
               d.cnt = q.cnt - 10'h001;
            end
         end
         occb_pkg::PH_SLOW: begin
            if (q.cnt == 10'h000) begin
               d.phase = occb_pkg::PH_ON;
            end else begin
               d.cnt = q.cnt - 10'h001;
            end
         end
      endcase
      if (!enable) begin
         d.phase = occb_pkg::PH_IDLE;
         d.cnt   = 10'h000;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         q <= '{phase: occb_pkg::PH_IDLE, cnt: 10'h000, slowLen: 10'h000, offLen: 10'h000};
      end else begin
         q <= d;
      end
   end

   // on drives forward, fast decay reverses, slow decay recirculates via low sides
   always_comb begin
      hbOne = '0;
      hbTwo = '0;
      unique case (q.phase)
         occb_pkg::PH_IDLE: begin
            hbOne = '0;
         end
         occb_pkg::PH_ON: begin
            hbOne = polarity ? 2'b01 : 2'b10;
            hbTwo = polarity ? 2'b10 : 2'b01;
         end
         occb_pkg::PH_FAST: begin
            hbOne = polarity ? 2'b10 : 2'b01;
            hbTwo = polarity ? 2'b01 : 2'b10;
         end
         occb_pkg::PH_SLOW: begin
            hbOne = 2'b01;
            hbTwo = 2'b01;
         end
      endcase
   end

   assign phase = q.phase;

   a_on_phase_ends: assert property (
      @(posedge sys_clk) disable iff (reset)
      (q.phase == occb_pkg::PH_ON && cmpTrip && enable && cfg.chopperStyleSelect
       && cfg.fastDecayDuration != 4'h0)
      |=> (q.phase == occb_pkg::PH_FAST
           && q.cnt == 10'({$past(cfg.fastDecayDuration), 5'h00}) - 10'h001))
      else $error("on phase did not end in fast decay");

   a_fd_zero_slow: assert property (
      @(posedge sys_clk) disable iff (reset)
      (q.phase == occb_pkg::PH_ON && cmpTrip && enable
       && (!cfg.chopperStyleSelect || cfg.fastDecayDuration == 4'h0))
      |=> q.phase == occb_pkg::PH_SLOW)
      else $error("zero fast decay did not go straight to slow decay");

   a_time_only_fast: assert property (
      @(posedge sys_clk) disable iff (reset)
      (q.phase == occb_pkg::PH_FAST && cfg.timeOnly && q.cnt != 10'h000 && enable)
      |=> q.phase == occb_pkg::PH_FAST)
      else $error("fast decay ended early in time-only mode");

   a_slow_length: assert property (
      @(posedge sys_clk) disable iff (reset)
      (q.phase == occb_pkg::PH_SLOW && $past(q.phase) == occb_pkg::PH_FAST && enable
       && !cfg.rndEn && !$past(cfg.rndEn))
      |-> q.offLen == occb_pkg::OFF_BASE_CYC + 10'({$past(cfg.offTimeSetting), 5'h00}))
      else $error("slow decay length differs from base plus step times setting");

   a_slow_to_on: assert property (
      @(posedge sys_clk) disable iff (reset)
      ($past(q.phase) == occb_pkg::PH_SLOW && q.phase == occb_pkg::PH_ON)
      |-> $past(q.slowLen) + 10'h001 == $past(q.offLen))
      else $error("slow decay did not last the programmed off time");

endmodule
`default_nettype wire

// [dv/occb_bridge_model.sv]
`timescale 1ns/100ps
`default_nettype none
module occb_bridge_model #(
   parameter int DLY  = 3,
   parameter int PEAK = 40,
   parameter int NEG  = 8
) (
   input  wire logic       sys_clk,
   input  wire logic [3:0] hiGate,
   input  wire logic [3:0] loGate,
   output logic [3:0]      hiGateOffPin = 4'hf,
   output logic [3:0]      loGateOffPin = 4'hf,
   output logic [1:0]      chopCmp = 2'h0
);
   int   hiLow [4] = '{4{8}};
   int   loLow [4] = '{4{8}};
   int   cur [2]   = '{2{0}};
   logic fwd;
   logic rev;
   always @(posedge sys_clk) begin
      // a gate reads discharged only some clocks after release
      for (int i = 0; i < 4; i++) begin
         hiLow[i] = hiGate[i] ? 0 : hiLow[i] + 1;
         loLow[i] = loGate[i] ? 0 : loLow[i] + 1;
         hiGateOffPin[i] <= hiLow[i] > DLY;
         loGateOffPin[i] <= loLow[i] > DLY;
      end
      // current ramps while driven, drifts to zero in slow decay
      for (int c = 0; c < 2; c++) begin
         fwd = hiGate[2*c] && loGate[2*c+1];
         rev = hiGate[2*c+1] && loGate[2*c];
         cur[c] += fwd ? 1 : rev ? -1 : cur[c] > 0 ? -1 : cur[c] < 0 ? 1 : 0;
         chopCmp[c] <= (fwd && cur[c] >= PEAK) || (rev && cur[c] <= -NEG);
      end
   end
endmodule
`default_nettype wire

// [dv/occb_bridge_ctl_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module occb_bridge_ctl_tb_top;
   logic        sys_clk = 1'b0;
   logic        reset = 1'b1;
   logic        bridge_disable_n = 1'b0;  // disable pin held low so the bridge is enabled
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, coilTargetA, coilTargetB;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf, hiGate, loGate, hiGateOffPin, loGateOffPin, pH, pL;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, hsTempComp;
   logic [1:0]  s_axi_bresp, s_axi_rresp, chopCmp, lsDrive, hsDrive, rsp;
   int          mismatches = 0, tests_run = 0, cyc = 0, tH0, tH1, tL, per;
   int          slowLen, fastLen, hr1, hr2;
   event        cycEnd;
   localparam logic [7:0] CTL = occb_pkg::ADDR_CTRL;
   localparam logic [7:0] TGT = occb_pkg::ADDR_TARGET;
   always #5 sys_clk = ~sys_clk;
   occb_bridge_ctl u_dut (.sys_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bridge_disable_n, .chopCmp,
      .hiGateOffPin, .loGateOffPin, .hiGate, .loGate, .coilTargetA, .coilTargetB,
      .lsDrive, .hsDrive, .hsTempComp);
   occb_bridge_model u_far (.sys_clk, .hiGate, .loGate, .hiGateOffPin, .loGateOffPin, .chopCmp);
   // phase edges of coil A and coil B high-side rises, read mid-cycle when gates are settled
   always @(negedge sys_clk) begin
      cyc++;
      if (pH[0] && !hiGate[0]) tH0 = cyc;
      if (pH[1] && !hiGate[1]) tH1 = cyc;
      if (!pH[1] && hiGate[1]) hr1++;
      if (!pH[2] && hiGate[2]) hr2++;
      if (pL[0] && !loGate[0]) begin
         slowLen = cyc - tH1;
         fastLen = tH1 - tH0;
         per = cyc - tL;
         tL = cyc;
         -> cycEnd;
      end
      for (int i = 0; i < 4; i++)
         if ((hiGate[i] && loGate[i]) || (hiGate[i] && !pH[i] && !loGateOffPin[i])
               || (loGate[i] && !pL[i] && !hiGateOffPin[i])) begin
            mismatches++;
            $display("mismatch guard%0d exp 0 got 1", i);
         end
      pH = hiGate;
      pL = loGate;
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch %s exp %h got %h", n, e, s);
      end
   endtask
   function automatic logic [31:0] cw(input logic [3:0] ot, fd, offs, input logic [2:0] f,
                                      input logic [1:0] sl);
      return {13'h0, sl, sl, f, offs, fd, ot};  // slopes kept equal
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge sys_clk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid;
         rsp = s_axi_bresp;
         @(posedge sys_clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end while (!tb);
      s_axi_bready <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd32(input logic [7:0] a, output logic [31:0] d);
      logic ta, tr;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge sys_clk);
         ta = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid;
         d = s_axi_rdata;
         @(posedge sys_clk);
         if (ta) s_axi_arvalid <= 1'b0;
      end while (!tr);
      s_axi_rready <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic waitc(input int n);
      repeat (n) @(cycEnd);
      @(posedge sys_clk);
   endtask
   task automatic t_reset;
      logic [31:0] d;
      rd32(CTL, d);
      chk("ctrl", 32'h0000_4300, d);
      rd32(TGT, d);
      chk("target", 32'h0, d);
      chk("gates", 32'h0, {24'h0, hiGate, loGate});
      wr(8'h40, 32'h1);
      chk("bresp", 32'h2, {30'h0, rsp});
   endtask
   task automatic t_slope;
      for (int c = 0; c < 4; c++) begin
         wr(CTL, cw(4'h0, 4'h0, 4'h3, 3'h4, 2'(c)));
         repeat (2) @(posedge sys_clk);
         chk("lsDrive", c < 2 ? 0 : c - 1, {30'h0, lsDrive});
         chk("hsDrive", c == 3 ? 2 : c == 2 ? 1 : 0, {30'h0, hsDrive});
         chk("hsTempComp", c == 1 || c == 2, {31'h0, hsTempComp});
      end
   endtask
   task automatic t_offset;
      logic [3:0] codes [5] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'hf};
      wr(TGT, 32'h0050_0064);
      foreach (codes[i]) begin
         wr(CTL, cw(4'h0, 4'h0, codes[i], 3'h4, 2'h0));
         repeat (2) @(posedge sys_clk);
         chk("coilTargetA", 32'd97 + codes[i], {24'h0, coilTargetA});
         chk("coilTargetB", 32'd77 + codes[i], {24'h0, coilTargetB});
      end
   endtask
   task automatic t_chop;
      int p, nv;
      wr(CTL, cw(4'h1, 4'h2, 4'h3, 3'h5, 2'h0));
      waitc(2);
      chk("slowLen", 56, slowLen);
      chk("fastLen", 64, fastLen);
      chk("coilB", 1, hr2 > 0);
      p = per;
      wr(CTL, cw(4'h1, 4'h2, 4'h3, 3'h4, 2'h0));
      waitc(2);
      chk("earlyEnd", 1, per < p - 32);
      wr(CTL, cw(4'h1, 4'h2, 4'h3, 3'h7, 2'h0));
      waitc(1);  // period in flight may still carry the old fast decay edge
      nv = 0;
      for (int k = 0; k < 8; k++) begin
         waitc(1);
         chk("rndSlow", 1, slowLen >= 56 && slowLen <= 71);
         if (slowLen != 56) nv++;
      end
      chk("rndVaries", 1, nv > 0);
   endtask
   task automatic t_style;
      logic [31:0] d;
      wr(CTL, cw(4'h1, 4'h5, 4'h3, 3'h0, 2'h0));
      rd32(occb_pkg::ADDR_HYST, d);
      chk("hyst", {16'h0, 7'h10, 5'h0, 4'h6}, {15'h0, d[16:0]});
      waitc(1);
      hr1 = 0;
      waitc(2);
      chk("noFastStyle0", 0, hr1);
      wr(CTL, cw(4'h1, 4'h0, 4'h3, 3'h4, 2'h0));
      waitc(1);
      hr1 = 0;
      waitc(2);
      chk("noFastTfd0", 0, hr1);
   endtask
   task automatic t_disable;
      logic [31:0] d;
      wr(CTL, cw(4'h1, 4'h2, 4'h3, 3'h5, 2'h0));
      waitc(2);
      bridge_disable_n <= 1'b1;
      repeat (10) @(posedge sys_clk);
      chk("gatesHw", 32'h0, {24'h0, hiGate, loGate});
      rd32(occb_pkg::ADDR_STATUS, d);
      chk("enabled", 32'h0, {31'h0, d[4]});
      bridge_disable_n <= 1'b0;
      waitc(2);
      wr(CTL, cw(4'h0, 4'h2, 4'h3, 3'h5, 2'h0));
      repeat (4) @(posedge sys_clk);
      chk("gatesSw", 32'h0, {24'h0, hiGate, loGate});
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge sys_clk);
      mismatches++;
      stop_test;
   end
   initial begin
      repeat (20) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      t_reset;
      t_slope;
      t_offset;
      t_chop;
      t_style;
      t_disable;
      stop_test;
   end
endmodule
`default_nettype wire
